// *** rtl/scratch_pin_regs.v ***
// Purpose: scratch registers and pin nine / global pin configuration
// Assumes: register port strobes are synchronous to sys_clk
// Notes:   pin_nine_oe_n is active low, all_pins_drive_en is active high
`default_nettype none
`include "scratch_pin_defs.vh"
module scratch_pin_regs (
    input  wire       sys_clk,
    input  wire       srst,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata_q,
    input  wire       remote_ctrl_en,
    input  wire       pin_nine_func_out,
    input  wire       pin_nine_in,
    output reg        pin_nine_out,
    output reg        pin_nine_oe_n,
    output reg        pin_nine_input_q,
    output wire       all_pins_drive_level,
    output wire       all_pins_func_sel,
    output wire       all_pins_drive_en,
    output wire       all_pins_input_sel
);
    ////////////////////////////////////////////////////////////////////////
    reg  [7:0] scratch0_q;
    reg  [7:0] scratch1_q;
    reg  [7:0] pincfg_q;
    reg        pin_in_s1_q;
    reg        pin_in_s2_q;
    wire       p9_func;
    wire       p9_drive;
    wire       p9_input;
    wire       p9_owned;

    // [R1] [R2] Scratch storage
    always @(posedge sys_clk) begin
        if (srst) begin
            scratch0_q <= `SCR0_RESET;
            scratch1_q <= `SCR1_RESET;
            pincfg_q   <= `PINCFG_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `SCR0_OFFSET) begin
                scratch0_q <= reg_wdata;
            end else if (reg_addr == `SCR1_OFFSET) begin
                scratch1_q <= reg_wdata;
            end else if (reg_addr == `PINCFG_OFFSET) begin
                // [R11] Reserved bits masked
                pincfg_q <= reg_wdata & `PINCFG_WMASK;
            end
        end
    end

    // Read data held until next read; unmapped offsets read zero
    always @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `SCR0_OFFSET) begin
                reg_rdata_q <= scratch0_q;
            end else if (reg_addr == `SCR1_OFFSET) begin
                reg_rdata_q <= scratch1_q;
            end else if (reg_addr == `PINCFG_OFFSET) begin
                reg_rdata_q <= pincfg_q & `PINCFG_WMASK;
            end else begin
                reg_rdata_q <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // [R5] [R7] Global mode pair
    pad_mode_decode u_global (
        .mode_pair (pincfg_q[`GLB_DIR_BIT:`GLB_EN_BIT]),
        .func_sel  (all_pins_func_sel),
        .drive_en  (all_pins_drive_en),
        .input_sel (all_pins_input_sel)
    );
    // [R4] Global level for unowned pins
    assign all_pins_drive_level = pincfg_q[`GLB_LEVEL_BIT];

    // [R9] [R10] Pin nine mode pair
    pad_mode_decode u_pin_nine (
        .mode_pair ({pincfg_q[`P9_DIR_BIT], pincfg_q[`P9_EN_BIT]}),
        .func_sel  (p9_func),
        .drive_en  (p9_drive),
        .input_sel (p9_input)
    );
    // Pin counts as owned once its own pair is non-zero
    assign p9_owned = pincfg_q[`P9_DIR_BIT] | pincfg_q[`P9_EN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // [R6] [R8] [R4] Pad drive selection
    always @* begin
        pin_nine_out  = pin_nine_func_out;
        pin_nine_oe_n = 1'b0;
        if (p9_owned) begin
            pin_nine_oe_n = ~p9_drive;
            if (!p9_func && !remote_ctrl_en) begin
                pin_nine_out = pincfg_q[`P9_LEVEL_BIT];
            end
        end else if (!all_pins_func_sel) begin
            pin_nine_oe_n = ~all_pins_drive_en;
            pin_nine_out  = pincfg_q[`GLB_LEVEL_BIT];
        end
    end

    // Pad input synchronised before use
    always @(posedge sys_clk) begin
        if (srst) begin
            pin_in_s1_q      <= 1'b0;
            pin_in_s2_q      <= 1'b0;
            pin_nine_input_q <= 1'b0;
        end else begin
            pin_in_s1_q      <= pin_nine_in;
            pin_in_s2_q      <= pin_in_s1_q;
            pin_nine_input_q <= (p9_input | (~p9_owned & all_pins_input_sel)) & pin_in_s2_q;
        end
    end
endmodule
`default_nettype wire

// *** rtl/scratch_pin_defs.vh ***
// What this block does
// [R1] Two 8-bit scratch registers, plain read/write
// [R2] Reset: first scratch 0x00, second 0x01
// [R3] Link controllers define any message protocol
// [R4] Unowned pins drive global level when output
// [R5] Global pair selects functional/tristate/force modes
// [R6] Pin settings override global settings
// [R7] Global direction bit 5, enable bit 4
// [R8] Pin nine drives level when locally output; code drives pin_nine_func_out instead while remote_ctrl_en is high
// [R9] Pin nine pair selects functional/tristate/gp modes
// [R10] Pin nine direction bit 1, enable 0
// [R11] Reserved bits 6 and 2 read zero
//
// Purpose: offsets, fields and reset values of the scratch and pin config slice
// Assumes: 8-bit register access at byte offsets
// Notes:   definitions only
`ifndef SCRATCH_PIN_DEFS_VH
`define SCRATCH_PIN_DEFS_VH
`define SCR0_OFFSET     8'h18
`define SCR1_OFFSET     8'h19
`define PINCFG_OFFSET   8'h1A
`define SCR0_RESET      8'h00
`define SCR1_RESET      8'h01
`define PINCFG_RESET    8'h00
`define PINCFG_WMASK    8'hBB
`define GLB_LEVEL_BIT   7
`define GLB_DIR_BIT     5
`define GLB_EN_BIT      4
`define P9_LEVEL_BIT    3
`define P9_DIR_BIT      1
`define P9_EN_BIT       0
`define MODE_FUNC       2'b00
`define MODE_TRI        2'b10
`define MODE_OUT        2'b01
`define MODE_IN         2'b11
`endif

// *** rtl/pad_mode_decode.v ***
// Purpose: turns a {direction, enable} pair into pad controls
// Assumes: pair coding shared by global and per-pin fields
// Notes:   combinational
`default_nettype none
`include "scratch_pin_defs.vh"
module pad_mode_decode (
    input  wire [1:0] mode_pair,
    output reg        func_sel,
    output reg        drive_en,
    output reg        input_sel
);
    // [R5] [R9] Pair decoding
    always @* begin
        func_sel  = 1'b0;
        drive_en  = 1'b0;
        input_sel = 1'b0;
        case (mode_pair)
            `MODE_FUNC: begin
                func_sel = 1'b1;
                drive_en = 1'b1;
            end
            `MODE_OUT: drive_en = 1'b1;
            `MODE_IN: input_sel = 1'b1;
            default: drive_en = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// *** dv/pin_pad.sv ***
// Purpose: pin nine pad with a pull-up
// Assumes: nothing else drives the pad
// Notes: a released pad reads high
`default_nettype none
module pin_pad (
    input  wire logic oe_n,
    input  wire logic drv,
    output wire logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up when released
    assign pin = oe_n ? 1'h1 : drv;
endmodule
`default_nettype wire

// *** dv/scratch_pin_chk.sv ***
// Purpose: port checks
// Assumes: a write shows a cycle later
// Notes: sees ports only
`default_nettype none
module scratch_pin_chk (
    input wire logic       sys_clk,
    input wire logic       srst,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic       remote_ctrl_en,
    input wire logic       pin_nine_oe_n,
    input wire logic       pin_nine_out,
    input wire logic       all_pins_drive_level,
    input wire logic       all_pins_input_sel,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_q
);
timeunit 1ns;
timeprecision 1ps;
default clocking @(posedge sys_clk); endclocking
default disable iff (srst);
wire cfg_hit = reg_addr == 8'h1A;
wire cfg_wr = reg_wr && cfg_hit;
sequence s_scr; reg_wr && reg_addr == 8'h18 ##1 reg_rd && reg_addr == 8'h18; endsequence
sequence s_loc; cfg_wr && reg_wdata[1:0] == 2'h1 ##1 !remote_ctrl_en; endsequence
a_rst_state: assert property ($fell(srst) |-> reg_rdata_q == 8'h00 && !pin_nine_oe_n) else $error("reset");
a_scr_back: assert property (s_scr |=> reg_rdata_q == $past(reg_wdata, 2)) else $error("readback");
a_rsvd_zero: assert property (reg_rd && cfg_hit |=> !reg_rdata_q[6] && !reg_rdata_q[2]) else $error("reserved");
a_glb_input: assert property (cfg_wr |=> all_pins_input_sel == &$past(reg_wdata[5:4])) else $error("input");
a_glb_level: assert property (cfg_wr |=> all_pins_drive_level == $past(reg_wdata[7])) else $error("level");
a_pin_tri: assert property (cfg_wr && reg_wdata[1:0] == 2'h2 |=> pin_nine_oe_n) else $error("tristate");
a_pin_local: assert property (s_loc |-> !pin_nine_oe_n && pin_nine_out == $past(reg_wdata[3]))
    else $error("local");
a_glb_force: assert property (
    cfg_wr && reg_wdata[5:0] == 6'h10 |=> !pin_nine_oe_n && pin_nine_out == $past(reg_wdata[7]))
    else $error("force");
endmodule
bind scratch_pin_regs scratch_pin_chk CHK (.*);
`default_nettype wire

// *** dv/tb.sv ***
// Purpose: register and pad test
// Assumes: inputs move at falling edges
// Notes: pad pulled high when released
`default_nettype none
module tb;
timeunit 1ns;
timeprecision 1ps;
logic sys_clk = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, remote_ctrl_en = 1'h0;
logic pin_nine_func_out = 1'h1, pin_nine_out, pin_nine_oe_n, pin_nine_input_q, pin_nine_in;
logic all_pins_drive_level, all_pins_func_sel, all_pins_drive_en, all_pins_input_sel;
logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q;
logic [15:0] tbl [7] = '{16'h000D, 16'h1004, 16'h2002, 16'h9005, 16'h3002, 16'h1905, 16'h1206};
int mismatches = 0, checked = 0;
always #2 sys_clk = ~sys_clk;
scratch_pin_regs DUT (.*);
pin_pad PAD (.oe_n(pin_nine_oe_n), .drv(pin_nine_out), .pin(pin_nine_in));
task chk(input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
        mismatches++;
        $display("BAD %0t mismatch %h", $time, s);
    end
endtask
task wr(input logic [7:0] a, d);
    @(negedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} = {1'h1, a, d};
    @(negedge sys_clk);
    reg_wr = 1'h0;
endtask
task rd(input logic [7:0] a, e);
    {reg_rd, reg_addr} = {1'h1, a};
    @(negedge sys_clk);
    reg_rd = 1'h0;
    @(negedge sys_clk);
    chk(reg_rdata_q, e);
endtask
task end_sim;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask
initial begin
    repeat (20) @(negedge sys_clk);
    srst = 1'h0;
    rd(8'h18, 8'h00);
    rd(8'h19, 8'h01);
    wr(8'h18, 8'hA5);
    rd(8'h18, 8'hA5);
    wr(8'h19, 8'h5A);
    rd(8'h19, 8'h5A);
    wr(8'h1B, 8'hFF);
    rd(8'h1B, 8'h00);
    rd(8'h18, 8'hA5);
    wr(8'h1A, 8'hFF);
    rd(8'h1A, 8'hBB);
    // Tristate hides the level, so it is masked
    foreach (tbl[i]) begin
        wr(8'h1A, tbl[i][15:8]);
        chk({4'h0, all_pins_func_sel, all_pins_drive_en, pin_nine_oe_n, pin_nine_out & ~pin_nine_oe_n}, tbl[i][7:0]);
    end
    chk({7'h00, pin_nine_input_q}, 8'h00);
    wr(8'h1A, 8'h33);
    repeat (5) @(negedge sys_clk);
    chk({6'h00, all_pins_input_sel, pin_nine_input_q}, 8'h03);
    remote_ctrl_en = 1'h1;
    wr(8'h1A, 8'h11);
    chk({6'h00, pin_nine_oe_n, pin_nine_out}, 8'h01);
    pin_nine_func_out = 1'h0;
    @(negedge sys_clk);
    chk({6'h00, pin_nine_oe_n, pin_nine_out}, 8'h00);
    end_sim;
end
endmodule
`default_nettype wire
